// file: common/uart_pkg.sv
// Shared constants, field layouts and helpers of the serial core.
package uart_pkg;

	// ****************************************************************
	// Clocking
	// ****************************************************************
	localparam int CLK_MHZ = 200;
	localparam int SRC_MHZ = 24;
	localparam logic [7:0] SRC_STEP = 8'(SRC_MHZ);
	localparam logic [7:0] SRC_WRAP = 8'(CLK_MHZ);
	localparam logic [3:0] BIT_TICKS_LAST = 4'hf;
	localparam logic [3:0] HALF_BIT_LAST = 4'h7;

	// ****************************************************************
	// Register map, word index within the 32-byte window
	// ****************************************************************
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_LFC = 3'h1;
	localparam logic [2:0] IDX_LSR = 3'h2;
	localparam logic [2:0] IDX_MODE = 3'h3;
	localparam logic [2:0] IDX_AUX = 3'h4;
	localparam logic [2:0] IDX_BANK = 3'h7;
	localparam logic [2:0] IDX_DIV_LO = 3'h0;
	localparam logic [2:0] IDX_DIV_HI = 3'h1;
	localparam logic [2:0] IDX_XC2 = 3'h2;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [4:0] PRESC_RST = 5'h0d;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic [7:0] LFC_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [2:0] BANK_RST = 3'h0;

	// ****************************************************************
	// Field layouts
	// ****************************************************************
	typedef struct packed {
		logic rsvd;
		logic brk;
		logic stick;
		logic even;
		logic par_en;
		logic stop2;
		logic [1:0] len;
	} lfc_s;

	typedef struct packed {
		logic rx_err;
		logic tx_idle;
		logic thr_empty;
		logic brk;
		logic frame;
		logic parity;
		logic overrun;
		logic ready;
	} lsr_s;

	typedef struct packed {
		logic [4:0] rsvd;
		logic [1:0] ir_mode;
		logic ext_en;
	} mode_s;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [7:0] len_mask(input logic [1:0] len);
		len_mask = 8'hff >> (2'h3 - len);
	endfunction : len_mask

	function automatic logic parity_of(input logic [7:0] d, input lfc_s f);
		logic x;
		x = ^(d & len_mask(f.len));
		if (f.stick) begin
			parity_of = ~f.even;
		end else begin
			parity_of = f.even ? x : ~x;
		end
	endfunction : parity_of

endpackage : uart_pkg

// file: rtl/serial_receiver.sv
// Receive channel: line synchroniser, start search and bit sampling.
`timescale 1ns/10ps
module serial_receiver
	import uart_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Timing and format
	input wire logic tick16_i,
	input lfc_s fmt_i,
	// Line
	input wire logic line_i,
	// Received character
	output logic done_o,
	output logic [7:0] data_o,
	output logic par_err_o,
	output logic frame_err_o,
	output logic brk_o
);

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
		rx_state_e;

	logic s1_ff, s2_ff, s3_ff, lvl_ff, lvl_d_ff;
	rx_state_e st_ff;
	logic [3:0] tk_ff;
	logic [2:0] bit_ff;
	logic [7:0] sh_ff;
	logic par_ff;
	logic all0_ff;
	logic mid;

	// ****************************************************************
	// Line input filter
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		s1_ff <= line_i;
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
		if (!rst_n_i) begin
			lvl_ff <= 1'b1;
			lvl_d_ff <= 1'b1;
		end else begin
			if (s2_ff == s3_ff) begin
				lvl_ff <= s3_ff;
			end
			lvl_d_ff <= lvl_ff;
		end
	end

	// Centre of a bit: the half-bit wait is done in RX_START.
	assign mid = tick16_i && (tk_ff == BIT_TICKS_LAST);

	// ****************************************************************
	// Sampling state machine
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		if (!rst_n_i) begin
			st_ff <= RX_IDLE;
			tk_ff <= 4'h0;
			bit_ff <= 3'h0;
			sh_ff <= 8'h00;
			par_ff <= 1'b0;
			all0_ff <= 1'b0;
			data_o <= 8'h00;
			par_err_o <= 1'b0;
			frame_err_o <= 1'b0;
			brk_o <= 1'b0;
		end else begin
			if (tick16_i && st_ff != RX_IDLE) begin
				tk_ff <= tk_ff + 4'h1;
			end
			case (st_ff)
				RX_IDLE: begin
					tk_ff <= 4'h0;
					if (lvl_d_ff && !lvl_ff) begin
						st_ff <= RX_START;
					end
				end
				RX_START: begin
					if (tick16_i && tk_ff == HALF_BIT_LAST) begin
						tk_ff <= 4'h0;
						bit_ff <= 3'h0;
						sh_ff <= 8'h00;
						all0_ff <= 1'b1;
						st_ff <= lvl_ff ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (mid) begin
						sh_ff[bit_ff] <= lvl_ff;
						all0_ff <= all0_ff & ~lvl_ff;
						bit_ff <= bit_ff + 3'h1;
						if (bit_ff == {1'b1, fmt_i.len}) begin
							st_ff <= fmt_i.par_en ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (mid) begin
						par_ff <= lvl_ff;
						all0_ff <= all0_ff & ~lvl_ff;
						st_ff <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (mid) begin
						done_o <= 1'b1;
						data_o <= sh_ff & len_mask(fmt_i.len);
						par_err_o <= fmt_i.par_en &&
							(par_ff != parity_of(sh_ff, fmt_i));
						frame_err_o <= !lvl_ff;
						brk_o <= all0_ff && !lvl_ff;
						st_ff <= RX_IDLE;
					end
				end
				default: begin
					st_ff <= RX_IDLE;
				end
			endcase
		end
	end

endmodule : serial_receiver

// file: rtl/uart_serial_core.sv
// Wired serial core with banked registers behind an AHB-Lite slave.
//
// Behaviour
// - Transmit and receive channels run concurrently.
// - Start, 5 to 8 data, parity, stop.
// - Data bits travel least significant first.
// - Reset selects basic legacy mode, extensions off.
// - Extended mode swaps scratch for auxiliary register.
// - Shared divisor counter, divides by 1 to 65535.
// - 24 MHz source through prescaler, reset 13.
// - Prescaler choice reaches up to 1.5 Mbaud.
// - Status readable anytime: full, empty, errors, break; here only with bank 0 selected.
// - Serial output marks after reset and infrared.
// - Baud source derived from the single clock.
// - Register banks 0 to 7, main in 0.
// - Reset aborts all activity, device disabled.
// - Address lines with select pick the register.
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module uart_serial_core
	import uart_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	// AHB-Lite slave
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	// Serial line
	input wire logic SERIAL_LINE_IN_I,
	output logic SERIAL_LINE_OUT_O
);

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
		tx_state_e;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic accept;
	logic rd_take;
	logic [2:0] acc_idx;
	logic acc_main;
	logic acc_hit;
	logic wr_pend_ff;
	logic [2:0] wr_idx_ff;
	logic wr_main_ff;
	logic wr_hit_ff;
	logic [7:0] wbyte;
	logic [7:0] nxt_rd;
	logic [31:0] hrdata_ff;

	lfc_s lfc_ff;
	mode_s mode_ff;
	logic [2:0] bank_ff;
	logic [7:0] scratch_ff;
	logic [7:0] aux_ctl_ff;
	logic [15:0] div_ff;
	logic [4:0] presc_ff;

	logic [7:0] src_acc_ff;
	logic src_tick_ff;
	logic [4:0] pre_cnt_ff;
	logic pre_tick_ff;
	logic [15:0] div_cnt_ff;
	logic tick16_ff;

	logic [7:0] thr_ff;
	logic thr_full_ff;
	tx_state_e tx_st_ff;
	logic [3:0] tx_tk_ff;
	logic [2:0] tx_bit_ff;
	logic [7:0] tx_sh_ff;
	logic tx_lvl_ff;
	logic tx_load;
	logic tx_bit_end;

	logic rx_done;
	logic [7:0] rx_data;
	logic rx_par;
	logic rx_frame;
	logic rx_brk;
	logic [7:0] rbr_ff;
	logic ready_ff;
	logic overrun_ff;
	logic par_err_ff;
	logic frame_err_ff;
	logic brk_ff;
	lsr_s lsr;

	logic wr_data;
	logic rd_data;
	logic rd_lsr;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	// Zero wait states: every transfer completes in its first data phase.
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
	assign HRDATA_O = hrdata_ff;

	assign accept = HSEL_I && HTRANS_I[1] && HREADY_I;
	assign rd_take = accept && !HWRITE_I;
	assign acc_idx = HADDR_I[4:2];
	// Within each 256 bytes, anything beyond the 32-byte window is unmapped and reads zero.
	assign acc_hit = (HADDR_I[7:5] == 3'h0);
	assign acc_main = (bank_ff == 3'h0) || (acc_idx == IDX_BANK);
	assign wbyte = HWDATA_I[7:0];

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= 3'h0;
			wr_main_ff <= 1'b0;
			wr_hit_ff <= 1'b0;
		end else begin
			wr_pend_ff <= accept && HWRITE_I;
			wr_idx_ff <= acc_idx;
			wr_main_ff <= acc_main;
			wr_hit_ff <= acc_hit;
		end
	end

	assign wr_data = wr_pend_ff && wr_hit_ff && wr_main_ff &&
		(wr_idx_ff == IDX_DATA);
	assign rd_data = rd_take && acc_hit && acc_main && (acc_idx == IDX_DATA);
	assign rd_lsr = rd_take && acc_hit && acc_main && (acc_idx == IDX_LSR);

	function automatic logic wr_at(input logic main, input logic [2:0] idx,
		input logic pend, input logic hit, input logic wmain,
		input logic [2:0] widx);
		wr_at = pend && hit && (wmain == main) && (widx == idx);
	endfunction : wr_at

	// ****************************************************************
	// Control registers
	// ****************************************************************
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			lfc_ff <= LFC_RST;
			mode_ff <= MODE_RST;
			bank_ff <= BANK_RST;
			scratch_ff <= 8'h00;
			aux_ctl_ff <= 8'h00;
		end else begin
			if (wr_at(1'b1, IDX_LFC, wr_pend_ff, wr_hit_ff, wr_main_ff,
				wr_idx_ff)) begin
				lfc_ff <= wbyte;
			end
			if (wr_at(1'b1, IDX_MODE, wr_pend_ff, wr_hit_ff, wr_main_ff,
				wr_idx_ff)) begin
				mode_ff <= {5'h00, wbyte[2:0]};
			end
			if (wr_pend_ff && wr_hit_ff && wr_idx_ff == IDX_BANK) begin
				bank_ff <= wbyte[2:0];
			end
			if (wr_at(1'b1, IDX_AUX, wr_pend_ff, wr_hit_ff, wr_main_ff,
				wr_idx_ff)) begin
				if (mode_ff.ext_en) begin
					aux_ctl_ff <= {wbyte[7:2], 2'b00};
				end else begin
					scratch_ff <= wbyte;
				end
			end
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			div_ff <= DIV_RST;
			presc_ff <= PRESC_RST;
		end else begin
			if (wr_at(1'b0, IDX_DIV_LO, wr_pend_ff, wr_hit_ff, wr_main_ff,
				wr_idx_ff)) begin
				div_ff[7:0] <= wbyte;
			end
			if (wr_at(1'b0, IDX_DIV_HI, wr_pend_ff, wr_hit_ff, wr_main_ff,
				wr_idx_ff)) begin
				div_ff[15:8] <= wbyte;
			end
			if (wr_at(1'b0, IDX_XC2, wr_pend_ff, wr_hit_ff, wr_main_ff,
				wr_idx_ff)) begin
				presc_ff <= wbyte[4:0];
			end
		end
	end

	// ****************************************************************
	// Baud generator
	// ****************************************************************
	// A 24 MHz tick is made from the core clock by a phase accumulator.
	// Its jitter is one core period, far below a sixteenth of a bit.
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			src_acc_ff <= 8'h00;
			src_tick_ff <= 1'b0;
		end else if (src_acc_ff + SRC_STEP >= SRC_WRAP) begin
			src_acc_ff <= src_acc_ff + SRC_STEP - SRC_WRAP;
			src_tick_ff <= 1'b1;
		end else begin
			src_acc_ff <= src_acc_ff + SRC_STEP;
			src_tick_ff <= 1'b0;
		end
	end

	// A prescaler or divisor of zero behaves as one.
	always_ff @(posedge CLOCK_I) begin
		pre_tick_ff <= 1'b0;
		if (!RST_N_I) begin
			pre_cnt_ff <= 5'h00;
		end else if (src_tick_ff) begin
			if (pre_cnt_ff + 5'h01 >= presc_ff) begin
				pre_cnt_ff <= 5'h00;
				pre_tick_ff <= 1'b1;
			end else begin
				pre_cnt_ff <= pre_cnt_ff + 5'h01;
			end
		end
	end

	always_ff @(posedge CLOCK_I) begin
		tick16_ff <= 1'b0;
		if (!RST_N_I) begin
			div_cnt_ff <= 16'h0000;
		end else if (pre_tick_ff) begin
			if (div_cnt_ff + 16'h0001 >= div_ff) begin
				div_cnt_ff <= 16'h0000;
				tick16_ff <= 1'b1;
			end else begin
				div_cnt_ff <= div_cnt_ff + 16'h0001;
			end
		end
	end

	// ****************************************************************
	// Transmit channel
	// ****************************************************************
	assign tx_load = (tx_st_ff == TX_IDLE) && thr_full_ff;
	assign tx_bit_end = tick16_ff && (tx_tk_ff == BIT_TICKS_LAST);

	// A new write wins over the shifter taking the holding byte.
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			thr_ff <= 8'h00;
			thr_full_ff <= 1'b0;
		end else if (wr_data) begin
			thr_ff <= wbyte;
			thr_full_ff <= 1'b1;
		end else if (tx_load) begin
			thr_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			tx_st_ff <= TX_IDLE;
			tx_tk_ff <= 4'h0;
			tx_bit_ff <= 3'h0;
			tx_sh_ff <= 8'h00;
			tx_lvl_ff <= 1'b1;
		end else begin
			if (tick16_ff && tx_st_ff != TX_IDLE) begin
				tx_tk_ff <= tx_tk_ff + 4'h1;
			end
			case (tx_st_ff)
				TX_IDLE: begin
					tx_lvl_ff <= 1'b1;
					tx_tk_ff <= 4'h0;
					if (tx_load) begin
						tx_sh_ff <= thr_ff & len_mask(lfc_ff.len);
						tx_st_ff <= TX_START;
						tx_lvl_ff <= 1'b0;
					end
				end
				TX_START: begin
					if (tx_bit_end) begin
						tx_bit_ff <= 3'h0;
						tx_lvl_ff <= tx_sh_ff[0];
						tx_st_ff <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (tx_bit_end) begin
						tx_bit_ff <= tx_bit_ff + 3'h1;
						if (tx_bit_ff == {1'b1, lfc_ff.len}) begin
							tx_lvl_ff <= lfc_ff.par_en ?
								parity_of(tx_sh_ff, lfc_ff) : 1'b1;
							tx_st_ff <= lfc_ff.par_en ? TX_PAR : TX_STOP;
						end else begin
							tx_lvl_ff <= tx_sh_ff[tx_bit_ff + 3'h1];
						end
					end
				end
				TX_PAR: begin
					if (tx_bit_end) begin
						tx_lvl_ff <= 1'b1;
						tx_st_ff <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (tx_bit_end) begin
						tx_st_ff <= TX_IDLE;
					end
				end
				default: begin
					tx_st_ff <= TX_IDLE;
				end
			endcase
		end
	end

	// Infrared modes force marking, even over the break bit, which otherwise forces spacing.
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			SERIAL_LINE_OUT_O <= 1'b1;
		end else if (mode_ff.ir_mode != 2'h0) begin
			SERIAL_LINE_OUT_O <= 1'b1;
		end else begin
			SERIAL_LINE_OUT_O <= tx_lvl_ff && !lfc_ff.brk;
		end
	end

	// ****************************************************************
	// Receive channel
	// ****************************************************************
	serial_receiver u_rx (
		.clk_i(CLOCK_I),
		.rst_n_i(RST_N_I),
		.tick16_i(tick16_ff),
		.fmt_i(lfc_ff),
		.line_i(SERIAL_LINE_IN_I),
		.done_o(rx_done),
		.data_o(rx_data),
		.par_err_o(rx_par),
		.frame_err_o(rx_frame),
		.brk_o(rx_brk)
	);

	// A character arriving with a clearing read is kept: set wins.
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			rbr_ff <= 8'h00;
			ready_ff <= 1'b0;
			overrun_ff <= 1'b0;
		end else begin
			if (rx_done) begin
				rbr_ff <= rx_data;
				ready_ff <= 1'b1;
			end else if (rd_data) begin
				ready_ff <= 1'b0;
			end
			if (rx_done && ready_ff && !rd_data) begin
				overrun_ff <= 1'b1;
			end else if (rd_lsr) begin
				overrun_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			par_err_ff <= 1'b0;
			frame_err_ff <= 1'b0;
			brk_ff <= 1'b0;
		end else if (rx_done) begin
			par_err_ff <= rx_par || (par_err_ff && !rd_lsr);
			frame_err_ff <= rx_frame || (frame_err_ff && !rd_lsr);
			brk_ff <= rx_brk || (brk_ff && !rd_lsr);
		end else if (rd_lsr) begin
			par_err_ff <= 1'b0;
			frame_err_ff <= 1'b0;
			brk_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// Status and read data
	// ****************************************************************
	always_comb begin
		lsr.ready = ready_ff;
		lsr.overrun = overrun_ff;
		lsr.parity = par_err_ff;
		lsr.frame = frame_err_ff;
		lsr.brk = brk_ff;
		lsr.thr_empty = !thr_full_ff;
		lsr.tx_idle = !thr_full_ff && (tx_st_ff == TX_IDLE);
		lsr.rx_err = par_err_ff || frame_err_ff || brk_ff;
	end

	always_comb begin
		nxt_rd = 8'h00;
		if (acc_hit && acc_idx == IDX_BANK) begin
			nxt_rd = {5'h00, bank_ff};
		end else if (acc_hit && acc_main) begin
			case (acc_idx)
				IDX_DATA: nxt_rd = rbr_ff;
				IDX_LFC: nxt_rd = lfc_ff;
				IDX_LSR: nxt_rd = lsr;
				IDX_MODE: nxt_rd = mode_ff;
				IDX_AUX: nxt_rd = mode_ff.ext_en ?
					{aux_ctl_ff[7:2], lsr.tx_idle, ready_ff} : scratch_ff;
				default: nxt_rd = 8'h00;
			endcase
		end else if (acc_hit) begin
			case (acc_idx)
				IDX_DIV_LO: nxt_rd = div_ff[7:0];
				IDX_DIV_HI: nxt_rd = div_ff[15:8];
				IDX_XC2: nxt_rd = {3'h0, presc_ff};
				default: nxt_rd = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (rd_take) begin
			hrdata_ff <= {24'h00_0000, nxt_rd};
		end
	end

endmodule : uart_serial_core

// file: tb/serial_peer_model.sv
// Far-end serial peer: sends and receives characters on the wire.
`timescale 1ns/10ps
module serial_peer_model
	import uart_pkg::*;
#(
	parameter real BIT_NS = 666.667
) (
	// Character format
	input lfc_s fmt_i,
	// Wire
	input wire logic line_i,
	output logic line_o,
	// Send request
	input wire logic send_i,
	input wire logic [7:0] data_i,
	input wire logic [1:0] kind_i,
	// Received character: stop, parity, data
	output logic got_o,
	output logic [9:0] got_data_o
);
	logic [7:0] rx_d;
	logic rx_p;

	function automatic logic par(input logic [7:0] d);
		logic [7:0] k;
		k = d & (8'hff >> (2'h3 - fmt_i.len));
		return fmt_i.stick ? ~fmt_i.even : (fmt_i.even ? ^k : ~^k);
	endfunction : par

	initial begin
		line_o = 1'b1;
		got_o = 1'b0;
		got_data_o = 10'h0;
	end
	// ****
	// Receive: a glitch shorter than half a bit is not a start.
	// ****
	always begin
		@(negedge line_i);
		#(BIT_NS / 2.0);
		if (line_i === 1'b0) begin
			rx_d = 8'h00;
			rx_p = 1'b0;
			for (int i = 0; i < 5 + fmt_i.len; i++) begin
				#(BIT_NS);
				rx_d[i] = line_i;
			end
			if (fmt_i.par_en) begin
				#(BIT_NS);
				rx_p = line_i;
			end
			#(BIT_NS);
			got_data_o = {line_i, rx_p, rx_d};
			got_o = 1'b1;
			#1;
			got_o = 1'b0;
		end
	end
	// ****
	// Send: kind 1 spoils the stop bit, kind 2 holds a break.
	// ****
	always @(posedge send_i) begin
		line_o = 1'b0;
		#(BIT_NS);
		if (kind_i == 2'h2) begin
			#(BIT_NS * 10.0);
		end else begin
			for (int i = 0; i < 5 + fmt_i.len; i++) begin
				line_o = data_i[i];
				#(BIT_NS);
			end
			if (fmt_i.par_en) begin
				line_o = par(data_i);
				#(BIT_NS);
			end
			line_o = (kind_i != 2'h1);
			#(BIT_NS);
		end
		line_o = 1'b1;
	end
endmodule : serial_peer_model

// file: tb/tb_legacy_uart_serial_core.sv
// Bench: registers, transmit formats, receive faults, reset.
`timescale 1ns/10ps
module tb_legacy_uart_serial_core
	import uart_pkg::*;
;
	typedef struct {
		string nm;
		logic [31:0] v;
		logic [31:0] m;
	} note_s;
	localparam int BIT = 134;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic to_dev;
	logic from_dev;
	lfc_s fmt = 8'h00;
	logic send = 1'b0;
	logic [7:0] sdata = 8'h00;
	logic [1:0] skind = 2'h0;
	logic got;
	logic [9:0] gdata;
	logic [31:0] seed = 32'hed59;
	logic [31:0] rd_val;
	logic mute = 1'b0;
	logic [7:0] fmts [6] = '{8'h03, 8'h00, 8'h09, 8'h1a, 8'h2b, 8'h3b};
	event rd_ev;
	note_s bus_q [$];
	note_s ser_q [$];
	int bad_count = 0;
	int total_checks = 0;

	always #2.5 clk = ~clk;

	uart_serial_core uut (
		.CLOCK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
		.HREADYOUT_O(hready), .HRESP_O(), .SERIAL_LINE_IN_I(to_dev),
		.SERIAL_LINE_OUT_O(from_dev)
	);
	serial_peer_model #(.BIT_NS(16000.0 / 24.0)) peer (
		.fmt_i(fmt), .line_i(from_dev), .line_o(to_dev), .send_i(send),
		.data_i(sdata), .kind_i(skind), .got_o(got), .got_data_o(gdata)
	);

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	function automatic logic [7:0] at(input logic [2:0] i);
		return {3'h0, i, 2'h0};
	endfunction : at

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[31] ? (s << 1) ^ 32'h04c11db7 : s << 1;
	endfunction : lfsr

	function automatic logic [31:0] frame_of(input logic [7:0] d);
		logic [7:0] k;
		logic p;
		k = d & (8'hff >> (2'h3 - fmt.len));
		p = fmt.stick ? ~fmt.even : (fmt.even ? ^k : ~^k);
		return {22'h0, 1'b1, p & fmt.par_en, k};
	endfunction : frame_of

	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hready !== 1'b1);
		rd_val = hrdata;
	endtask : xfer

	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		xfer(at(i), 1'b1, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] v,
		input string nm, input logic [31:0] m = '1);
		bus_q.push_back('{nm, v, m});
		xfer(a, 1'b0, 8'h00);
		-> rd_ev;
	endtask : rd

	task automatic tx(input logic [7:0] d);
		ser_q.push_back('{"tx frame", frame_of(d), '1});
		wr(IDX_DATA, d);
	endtask : tx

	task automatic peer_send(input logic [7:0] d, input logic [1:0] k);
		sdata <= d;
		skind <= k;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		repeat (12 * BIT) @(posedge clk);
	endtask : peer_send

	task automatic hold_high(input int n, input string nm);
		int lows;
		lows = 0;
		repeat (n) begin
			@(posedge clk);
			if (from_dev !== 1'b1) lows++;
		end
		check(nm, 32'(lows), 32'h0);
	endtask : hold_high

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	always @(rd_ev) begin
		note_s n;
		n = bus_q.pop_front();
		check(n.nm, rd_val & n.m, n.v);
	end

	always @(posedge got) begin
		note_s n;
		if (!mute && ser_q.size() == 0) begin
			check("extra frame", {22'h0, gdata}, 32'hx);
		end else if (!mute) begin
			n = ser_q.pop_front();
			check(n.nm, {22'h0, gdata}, n.v);
		end
	end

	// A hang cuts the run short; the span is about twice the plan.
	initial begin
		#400000;
		bad_count++;
		wrap_up();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(at(IDX_LSR), 8'h60, "status");
		rd(at(IDX_LFC), 8'h00, "format");
		rd(at(IDX_MODE), 8'h00, "mode");
		rd(8'h20, 8'h00, "unmapped");
		wr(IDX_BANK, 8'h01);
		rd(at(IDX_BANK), 8'h01, "bank");
		rd(at(IDX_DIV_LO), 8'h01, "divisor low");
		rd(at(IDX_DIV_HI), 8'h00, "divisor high");
		rd(at(IDX_XC2), 8'h0d, "prescaler");
		wr(IDX_XC2, 8'h01);
		wr(IDX_DIV_LO, 8'h01);
		wr(IDX_BANK, 8'h00);
		xfer(8'h24, 1'b1, 8'hff);
		rd(8'h24, 8'h00, "unmapped");
		wr(IDX_AUX, 8'ha5);
		rd(at(IDX_AUX), 8'ha5, "scratch");
		wr(IDX_MODE, 8'h01);
		wr(IDX_AUX, 8'h5c);
		rd(at(IDX_AUX), 8'h5e, "aux");
		wr(IDX_MODE, 8'h00);
		foreach (fmts[k]) begin
			fmt = fmts[k];
			wr(IDX_LFC, fmts[k]);
			rd(at(IDX_LFC), fmts[k], "format");
			repeat (2) begin
				seed = lfsr(seed);
				tx(seed[7:0]);
			end
			repeat (26 * BIT) @(posedge clk);
		end
		mute = 1'b1;
		for (int m = 1; m < 4; m++) begin
			wr(IDX_MODE, {5'h0, m[1:0], 1'b0});
			if (m == 1) wr(IDX_DATA, 8'h00);
			hold_high(4 * BIT, "infrared mark");
		end
		wr(IDX_MODE, 8'h00);
		wr(IDX_LFC, 8'h7b);
		repeat (2 * BIT) @(posedge clk);
		check("break out", {31'h0, from_dev}, 32'h0);
		wr(IDX_LFC, 8'h3b);
		repeat (14 * BIT) @(posedge clk);
		mute = 1'b0;
		seed = lfsr(seed);
		tx(seed[7:0]);
		peer_send(seed[15:8], 2'h0);
		rd(at(IDX_LSR), 8'h61, "status");
		rd(at(IDX_DATA), seed[15:8], "rx data");
		rd(at(IDX_LSR), 8'h60, "status");
		peer_send(8'ha5, 2'h1);
		rd(at(IDX_LSR), 8'h08, "framing", 8'h0e);
		rd(at(IDX_LSR), 8'h00, "cleared", 8'h0e);
		xfer(at(IDX_DATA), 1'b0, 8'h00);
		peer_send(8'h11, 2'h0);
		peer_send(8'h22, 2'h0);
		rd(at(IDX_LSR), 8'h03, "overrun", 8'h03);
		xfer(at(IDX_DATA), 1'b0, 8'h00);
		peer_send(8'h00, 2'h2);
		rd(at(IDX_LSR), 8'h10, "break", 8'h10);
		xfer(at(IDX_DATA), 1'b0, 8'h00);
		rd(at(IDX_LSR), 8'h00, "cleared", 8'h1e);
		mute = 1'b1;
		wr(IDX_DATA, 8'h0f);
		repeat (3 * BIT) @(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		hold_high(12 * BIT, "mark after reset");
		rd(at(IDX_LSR), 8'h60, "status");
		check("frames left", 32'(ser_q.size()), 32'h0);
		wrap_up();
	end
endmodule : tb_legacy_uart_serial_core

// file: tb/uart_serial_core_properties.sv
// Port assertions of the serial core.
`timescale 1ns/10ps
module uart_serial_core_checker (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	// Bus
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	input wire logic [31:0] HRDATA_O,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O,
	// Serial line
	input wire logic SERIAL_LINE_IN_I,
	input wire logic SERIAL_LINE_OUT_O
);
	logic out_q_ff;
	logic [7:0] run_ff;
	logic rd_take;
	assign rd_take = HSEL_I & HTRANS_I[1] & HREADY_I & ~HWRITE_I;
	// ****
	// Run length of the output; ticks come every 8 or 9 cycles, so 120.
	// ****
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			out_q_ff <= 1'b1;
			run_ff <= 8'hff;
		end else begin
			out_q_ff <= SERIAL_LINE_OUT_O;
			if (SERIAL_LINE_OUT_O != out_q_ff) begin
				run_ff <= 8'h00;
			end else if (run_ff != 8'hff) begin
				run_ff <= run_ff + 8'h01;
			end
		end
	end
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RST_N_I);
	sequence s_void_read;
		rd_take ##0 (HADDR_I[7:5] != 3'h0);
	endsequence
	sequence s_release;
		!RST_N_I ##1 RST_N_I;
	endsequence
	a_ready_high: assert property (HREADYOUT_O)
		else $error("hreadyout low");
	a_resp_okay: assert property (HRESP_O == 1'b0)
		else $error("hresp not okay");
	a_rdata_byte: assert property (HRDATA_O[31:8] == 24'h0)
		else $error("read data above byte");
	a_void_zero: assert property (s_void_read |=> HRDATA_O == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_stands: assert property (!rd_take |=> $stable(HRDATA_O))
		else $error("read data moved");
	a_reset_mark: assert property (disable iff (1'b0)
		!RST_N_I |=> SERIAL_LINE_OUT_O) else $error("no mark in reset");
	a_reset_bus: assert property (disable iff (1'b0)
		!RST_N_I |=> HRDATA_O == 32'h0) else $error("read data in reset");
	a_mark_release: assert property (disable iff (1'b0)
		s_release |-> SERIAL_LINE_OUT_O [*3]) else $error("no mark at start");
	a_bit_min_len: assert property (
		SERIAL_LINE_OUT_O != out_q_ff |-> run_ff >= 8'h78)
		else $error("serial bit too short");
endmodule : uart_serial_core_checker

bind uart_serial_core uart_serial_core_checker chk (
	.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I),
	.HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
	.HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
	.HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
	.SERIAL_LINE_IN_I(SERIAL_LINE_IN_I),
	.SERIAL_LINE_OUT_O(SERIAL_LINE_OUT_O)
);
